/* hdl/bcsr_pkg.sv */
// constants for the primary command and status configuration registers
package bcsr_pkg;
  // ==========================================================
  // register map
  localparam int unsigned CFG_ADDR_W = 8;
  localparam logic [7:0] OFS_PART_ID = 8'h00;
  localparam logic [7:0] OFS_CMD_STS = 8'h04;
  // ==========================================================
  // command word field positions
  localparam int unsigned CMD_IO_EN = 0;
  localparam int unsigned CMD_MEM_EN = 1;
  localparam int unsigned CMD_MASTER_EN = 2;
  localparam int unsigned CMD_PALETTE_EN = 5;
  localparam int unsigned CMD_PARITY_RESP = 6;
  localparam int unsigned CMD_SERR_EN = 8;
  localparam int unsigned CMD_FB2B_EN = 9;
  localparam logic [15:0] CMD_RW_MASK = 16'h0367;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // ==========================================================
  // status word: fixed bits (capability list, 66 MHz, fast b2b, medium select)
  localparam logic [15:0] STS_FIXED = 16'h02B0;
  // sticky flags, index into the flag vector
  localparam int unsigned NUM_FLAGS = 6;
  localparam int unsigned FLG_MST_DPERR = 0;
  localparam int unsigned FLG_SIG_TABORT = 1;
  localparam int unsigned FLG_RCV_TABORT = 2;
  localparam int unsigned FLG_RCV_MABORT = 3;
  localparam int unsigned FLG_SIG_SERR = 4;
  localparam int unsigned FLG_DET_PERR = 5;
  // bit position of each flag in the command/status doubleword
  localparam logic [5:0][4:0] FLAG_POS = {5'h1F, 5'h1E, 5'h1D, 5'h1C, 5'h1B, 5'h18};
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  // ==========================================================
  // palette snoop addresses, low ten bits of the i/o address
  localparam logic [9:0] PAL_ADDR_A = 10'h3C6;
  localparam logic [9:0] PAL_ADDR_B = 10'h3C8;
  localparam logic [9:0] PAL_ADDR_C = 10'h3C9;
endpackage

/* hdl/bcsr_flag_if.sv */
// carrier between the register logic and the sticky flag unit
`timescale 1ns/100ps
interface bcsr_flag_if #(
  parameter int unsigned NF = 6
);
  logic [NF-1:0] set;
  logic [NF-1:0] clr;
  logic [NF-1:0] flags;
  modport owner (input set, input clr, output flags);
  modport user (output set, output clr, input flags);
endinterface

/* hdl/bcsr_flags.sv */
// sticky write-one-to-clear flag unit
`timescale 1ns/100ps
module bcsr_flags #(
  parameter int unsigned NF = 6
) (
  input wire logic clk,
  input wire logic rst,
  bcsr_flag_if.owner fi
);
  typedef struct packed {
    logic [NF-1:0] flags;
  } bcsr_flg_state_t;

  bcsr_flg_state_t st_r;
  bcsr_flg_state_t st_nxt;
  logic [NF-1:0] bit_nxt;

  // ==========================================================
  // elaboration check
  if (NF < 1 || NF > 32) begin : g_chk
    $error("bcsr_flags: NF must be 1 to 32");
  end

  // ==========================================================
  // per flag: a set in the clearing cycle wins
  for (genvar i = 0; i < NF; i++) begin : g_bit
    assign bit_nxt[i] = fi.set[i] | (st_r.flags[i] & ~fi.clr[i]); // RULE22
  end

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.flags = bit_nxt;
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r.flags <= NF'(bcsr_pkg::FLAGS_RESET);
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fi.flags = st_r.flags;
endmodule // bcsr_flags

/* hdl/bcsr_cfg_regs.sv */
// primary command and status configuration registers of a pci-to-pci bridge
//
// Summary of operation
// RULE1: upper half of dword 00h holds a fixed read-only part identifier.
// RULE2: command bit 0 set lets the bridge answer primary i/o cycles; resets clear.
// RULE3: command bit 1 set lets the bridge answer primary memory cycles; resets clear.
// RULE4: command bit 2 gates primary mastering and secondary memory/io claims; resets clear.
// RULE5: command bits 3 and 7 are read-only and read zero.
// RULE6: command bit 4 is read-only and reads zero.
// RULE7: bit 5 set claims primary i/o writes to 3C6h, 3C8h, 3C9h, ten bits decoded.
// RULE8: bit 6 set enables normal parity error actions; clear lets them be ignored.
// RULE9: bit 8 enables the primary system error output driver; resets clear.
// RULE10: bit 9 permits fast back-to-back initiation on the primary; resets clear.
// RULE11: command bits 15 to 10 are reserved and read zero.
// RULE12: status bit 20 reads one, capability list pointer at offset 34h.
// RULE13: status bit 21 reads one, primary may run at 66 MHz.
// RULE14: status bit 23 reads one, fast back-to-back decode capable.
// RULE15: status bit 24 sets on master data parity error; write one clears.
// RULE16: status bits 26:25 read 01, medium select timing.
// RULE17: status bit 27 sets when the bridge target-aborts; write one clears.
// RULE18: status bit 28 sets when mastered cycle gets target abort; write one clears.
// RULE19: status bit 29 sets when mastered cycle ends in master abort; write one clears.
// RULE20: status bit 30 sets whenever the system error output is asserted; write one clears.
// RULE21: status bit 31 sets on any primary address or data parity error; write one clears.
// RULE22: sticky flags clear only where a one is written; zeros keep them.
// RULE23: read-only bits ignore writes; byte enables limit which bytes update.
`timescale 1ns/100ps
module bcsr_cfg_regs #(
  parameter logic [15:0] PART_ID = 16'h5A3C, // arbitrary value
  parameter int unsigned ADDR_W = bcsr_pkg::CFG_ADDR_W
) (
  input wire logic CLK,
  input wire logic RST,
  // configuration cycle access, one dword per request
  input wire logic CFG_REQ,
  input wire logic CFG_WR,
  input wire logic [ADDR_W-1:0] CFG_ADDR,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  output logic [31:0] CFG_RDATA,
  output logic CFG_ACK,
  // events from the primary bus engine
  input wire logic MST_DATA_PERR,
  input wire logic TGT_ABORT_SIGNALED,
  input wire logic MST_TGT_ABORT_RCVD,
  input wire logic MST_MASTER_ABORT_RCVD,
  input wire logic ADDR_PERR,
  input wire logic TGT_DATA_PERR,
  input wire logic SYS_ERR_REQ,
  // primary and secondary decode requests
  input wire logic PRI_IO_VALID,
  input wire logic PRI_IO_WRITE,
  input wire logic [15:0] PRI_IO_ADDR,
  input wire logic PRI_MEM_VALID,
  input wire logic SEC_MEMIO_VALID,
  // decode answers and permissions
  output logic IO_CLAIM,
  output logic MEM_CLAIM,
  output logic PALETTE_CLAIM,
  output logic SEC_CLAIM,
  output logic PRI_MASTER_PERMIT,
  output logic FB2B_PERMIT,
  output logic PERR_ACTION,
  // primary system error output, open drain
  output logic PRIMARY_SYSTEM_ERROR_OUT_N_O,
  output logic PRIMARY_SYSTEM_ERROR_OUT_OE
);
  // ==========================================================
  // types and state
  typedef struct packed {
    logic [15:0] cmd;
    logic ack;
    logic [31:0] rdata;
    logic io_claim;
    logic mem_claim;
    logic pal_claim;
    logic sec_claim;
    logic perr_act;
    logic serr_drv;
  } bcsr_state_t;

  localparam int unsigned NF = bcsr_pkg::NUM_FLAGS;
  // dword offsets at the bus address width; a narrow bus drops high bits on purpose
  localparam logic [ADDR_W-1:0] ADR_ID = ADDR_W'(bcsr_pkg::OFS_PART_ID);
  localparam logic [ADDR_W-1:0] ADR_CS = ADDR_W'(bcsr_pkg::OFS_CMD_STS);

  bcsr_state_t st_r;
  bcsr_state_t st_nxt;
  bcsr_flag_if #(.NF(NF)) flg ();
  logic [31:0] flag_word;
  logic [NF-1:0][31:0] placed;
  logic [31:0] cmd_sts_word;
  logic [15:0] cmd_wr;
  logic hit_id;
  logic hit_cs;
  logic wr_cs;
  logic io_en;
  logic mem_en;
  logic mst_en;
  logic pal_en;
  logic per_en;
  logic serr_en;
  logic pal_addr;
  logic serr_fire;

  // ==========================================================
  // elaboration check
  if (ADDR_W < 3 || ADDR_W > 12) begin : g_chk
    $error("bcsr_cfg_regs: ADDR_W must be 3 to 12");
  end

  // ==========================================================
  // sticky flag unit
  bcsr_flags #(
    .NF(NF)
  ) u_flags (
    .clk(CLK),
    .rst(RST),
    .fi(flg.owner)
  );

  // ==========================================================
  // command field views
  assign io_en = st_r.cmd[bcsr_pkg::CMD_IO_EN];
  assign mem_en = st_r.cmd[bcsr_pkg::CMD_MEM_EN];
  assign mst_en = st_r.cmd[bcsr_pkg::CMD_MASTER_EN];
  assign pal_en = st_r.cmd[bcsr_pkg::CMD_PALETTE_EN];
  assign per_en = st_r.cmd[bcsr_pkg::CMD_PARITY_RESP];
  assign serr_en = st_r.cmd[bcsr_pkg::CMD_SERR_EN];

  // ==========================================================
  // address decode of the configuration access
  always_comb begin
    hit_id = 1'b0;
    hit_cs = 1'b0;
    if (CFG_ADDR[ADDR_W-1:2] == ADR_ID[ADDR_W-1:2]) begin
      hit_id = 1'b1;
    end else if (CFG_ADDR[ADDR_W-1:2] == ADR_CS[ADDR_W-1:2]) begin
      hit_cs = 1'b1;
    end
  end

  assign wr_cs = CFG_REQ & CFG_WR & hit_cs;

  // ==========================================================
  // flag placement into the status half of the doubleword
  for (genvar i = 0; i < NF; i++) begin : g_flag
    logic [31:0] one_pos;
    assign one_pos = 32'(flg.flags[i]) << bcsr_pkg::FLAG_POS[i];
    // one placed word per flag, merged below
    assign placed[i] = one_pos;
    // clear only where a one is written to the flag's byte lane
    assign flg.clr[i] = wr_cs & CFG_BE[bcsr_pkg::FLAG_POS[i] / 8]
                      & CFG_WDATA[bcsr_pkg::FLAG_POS[i]]; // RULE22 RULE23
  end

  // or together the placed flags; flags sit at distinct bits, so none masks another
  always_comb begin
    flag_word = 32'h0000_0000;
    for (int i = 0; i < NF; i++) begin
      flag_word = flag_word | placed[i];
    end
  end

  // read view of dword 04h
  assign cmd_sts_word = {bcsr_pkg::STS_FIXED, st_r.cmd & bcsr_pkg::CMD_RW_MASK}
                      | flag_word; // RULE12 RULE13 RULE14 RULE16 RULE5 RULE6 RULE11

  // ==========================================================
  // command write merge with byte enables and writable mask
  always_comb begin
    cmd_wr = st_r.cmd;
    if (CFG_BE[0]) begin
      cmd_wr[7:0] = CFG_WDATA[7:0]; // RULE23
    end
    if (CFG_BE[1]) begin
      cmd_wr[15:8] = CFG_WDATA[15:8]; // RULE23
    end
    cmd_wr = cmd_wr & bcsr_pkg::CMD_RW_MASK; // RULE5 RULE6 RULE11
  end

  // ==========================================================
  // palette snoop: only the low ten address bits are compared
  assign pal_addr = (PRI_IO_ADDR[9:0] == bcsr_pkg::PAL_ADDR_A)
                  | (PRI_IO_ADDR[9:0] == bcsr_pkg::PAL_ADDR_B)
                  | (PRI_IO_ADDR[9:0] == bcsr_pkg::PAL_ADDR_C); // RULE7

  // with command bit 8 set, system error fires on a request, or an address parity error under parity response
  assign serr_fire = serr_en & (SYS_ERR_REQ | (ADDR_PERR & per_en)); // RULE9 RULE8

  // ==========================================================
  // event flag sets, taken on the cycle of the event
  always_comb begin
    flg.set = '0;
    flg.set[bcsr_pkg::FLG_MST_DPERR] = MST_DATA_PERR & per_en; // RULE15 RULE8
    flg.set[bcsr_pkg::FLG_SIG_TABORT] = TGT_ABORT_SIGNALED; // RULE17
    flg.set[bcsr_pkg::FLG_RCV_TABORT] = MST_TGT_ABORT_RCVD; // RULE18
    flg.set[bcsr_pkg::FLG_RCV_MABORT] = MST_MASTER_ABORT_RCVD; // RULE19
    flg.set[bcsr_pkg::FLG_SIG_SERR] = serr_fire; // RULE20
    flg.set[bcsr_pkg::FLG_DET_PERR] = ADDR_PERR | TGT_DATA_PERR | MST_DATA_PERR; // RULE21
  end

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    // configuration access answered one cycle after the request
    st_nxt.ack = CFG_REQ;
    if (CFG_REQ && !CFG_WR) begin
      if (hit_id) begin
        st_nxt.rdata = {PART_ID, 16'h0000}; // RULE1
      end else if (hit_cs) begin
        st_nxt.rdata = cmd_sts_word;
      end else begin
        st_nxt.rdata = 32'h0000_0000;
      end
    end
    // writes to the identifier dword and unmapped dwords are dropped
    if (wr_cs) begin
      st_nxt.cmd = cmd_wr; // RULE23
    end
    // decode answers gated by the command word
    st_nxt.io_claim = PRI_IO_VALID & io_en; // RULE2
    st_nxt.mem_claim = PRI_MEM_VALID & mem_en; // RULE3
    st_nxt.pal_claim = PRI_IO_VALID & PRI_IO_WRITE & pal_addr & pal_en; // RULE7
    st_nxt.sec_claim = SEC_MEMIO_VALID & mst_en; // RULE4
    // parity action only under parity response
    st_nxt.perr_act = per_en & (MST_DATA_PERR | TGT_DATA_PERR | ADDR_PERR); // RULE8
    // one-cycle drive of the system error pin
    st_nxt.serr_drv = serr_fire; // RULE9
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r.cmd <= bcsr_pkg::CMD_RESET; // RULE2 RULE3 RULE4 RULE7 RULE8 RULE9 RULE10
      st_r.ack <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
      st_r.io_claim <= 1'b0;
      st_r.mem_claim <= 1'b0;
      st_r.pal_claim <= 1'b0;
      st_r.sec_claim <= 1'b0;
      st_r.perr_act <= 1'b0;
      st_r.serr_drv <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs, all from flops except PRIMARY_SYSTEM_ERROR_OUT_N_O, which is tied low
  assign CFG_RDATA = st_r.rdata;
  assign CFG_ACK = st_r.ack;
  assign IO_CLAIM = st_r.io_claim;
  assign MEM_CLAIM = st_r.mem_claim;
  assign PALETTE_CLAIM = st_r.pal_claim;
  assign SEC_CLAIM = st_r.sec_claim;
  assign PRI_MASTER_PERMIT = st_r.cmd[bcsr_pkg::CMD_MASTER_EN]; // RULE4
  assign FB2B_PERMIT = st_r.cmd[bcsr_pkg::CMD_FB2B_EN]; // RULE10
  assign PERR_ACTION = st_r.perr_act;
  assign PRIMARY_SYSTEM_ERROR_OUT_N_O = 1'b0; // open drain: only pulls low
  assign PRIMARY_SYSTEM_ERROR_OUT_OE = st_r.serr_drv; // RULE9
endmodule // bcsr_cfg_regs

/* tb/bcsr_cfg_regs_assertions.sv */
// port checks for the command and status registers
`timescale 1ns/100ps
module bcsr_cfg_regs_assertions #(
  parameter logic [15:0] PART_ID = 16'h0000,
  parameter int unsigned ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CFG_REQ,
  input wire logic CFG_WR,
  input wire logic [ADDR_W-1:0] CFG_ADDR,
  input wire logic [31:0] CFG_RDATA,
  input wire logic CFG_ACK,
  input wire logic PRI_IO_VALID,
  input wire logic PRI_IO_WRITE,
  input wire logic [15:0] PRI_IO_ADDR,
  input wire logic PRI_MEM_VALID,
  input wire logic SEC_MEMIO_VALID,
  input wire logic IO_CLAIM,
  input wire logic MEM_CLAIM,
  input wire logic PALETTE_CLAIM,
  input wire logic SEC_CLAIM,
  input wire logic PERR_ACTION,
  input wire logic MST_DATA_PERR,
  input wire logic TGT_DATA_PERR,
  input wire logic ADDR_PERR,
  input wire logic SYS_ERR_REQ,
  input wire logic PRIMARY_SYSTEM_ERROR_OUT_OE
);
  logic pal_r;
  logic perr_r;
  logic serr_r;
  // registered causes of the one-cycle answers
  always_ff @(posedge CLK) begin
    pal_r <= PRI_IO_VALID && PRI_IO_WRITE && (PRI_IO_ADDR[9:0] inside {10'h3C6, 10'h3C8, 10'h3C9});
    perr_r <= MST_DATA_PERR || TGT_DATA_PERR || ADDR_PERR;
    serr_r <= SYS_ERR_REQ || ADDR_PERR;
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  sequence s_rd(dw);
    CFG_REQ && !CFG_WR && (CFG_ADDR[ADDR_W-1:2] == dw);
  endsequence
  AST_ACK: assert property (CFG_ACK == $past(CFG_REQ))
    else $error("ack not one cycle after request");
  AST_IO: assert property (!PRI_IO_VALID |=> !IO_CLAIM)
    else $error("io claim without request");
  AST_MEM: assert property (MEM_CLAIM |-> $past(PRI_MEM_VALID))
    else $error("memory claim without request");
  AST_SEC: assert property (SEC_CLAIM |-> $past(SEC_MEMIO_VALID))
    else $error("secondary claim without request");
  AST_PAL: assert property (PALETTE_CLAIM |-> pal_r)
    else $error("palette claim on wrong cycle");
  AST_PERR: assert property (PERR_ACTION |-> perr_r)
    else $error("parity action without parity error");
  AST_SERR: assert property (PRIMARY_SYSTEM_ERROR_OUT_OE |-> serr_r)
    else $error("system error driven without cause");
  AST_STS: assert property (s_rd(1) |=> (CFG_RDATA & 32'h06FF_FC98) == 32'h02B0_0000)
    else $error("fixed command or status bits wrong");
  AST_ID: assert property (s_rd(0) |=> CFG_RDATA[31:16] == PART_ID)
    else $error("part identifier wrong");
  AST_HOLD: assert property (!(CFG_REQ && !CFG_WR) |=> $stable(CFG_RDATA))
    else $error("read data changed without a read");
endmodule // bcsr_cfg_regs_assertions

/* tb/bcsr_host_model.sv */
// host model issuing one-dword configuration requests
`timescale 1ns/100ps
module bcsr_host_model #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic CLK,
  output logic CFG_REQ,
  output logic CFG_WR,
  output logic [ADDR_W-1:0] CFG_ADDR,
  output logic [3:0] CFG_BE,
  output logic [31:0] CFG_WDATA,
  input wire logic [31:0] CFG_RDATA,
  input wire logic CFG_ACK
);
  // idle request lines
  initial begin
    CFG_REQ = 1'b0;
    CFG_WR = 1'b0;
    CFG_ADDR = '0;
    CFG_BE = 4'h0;
    CFG_WDATA = 32'h0000_0000;
  end
  // one access: request for one edge, answer taken in the ack cycle
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q, output logic ak);
    CFG_REQ = 1'b1;
    CFG_WR = wr;
    CFG_ADDR = a;
    CFG_BE = be;
    CFG_WDATA = d;
    @(posedge CLK);
    #1;
    CFG_REQ = 1'b0;
    CFG_ADDR = ~a;
    CFG_WDATA = ~d;
    q = CFG_RDATA;
    ak = CFG_ACK;
    @(posedge CLK);
    #1;
  endtask
endmodule // bcsr_host_model

/* tb/tb_bcsr_cfg_regs.sv */
// self-checking bench for the command and status registers
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
  comparisons++; \
  if ((got) !== (ex)) begin \
    mismatches++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); \
  end \
end
module tb_bcsr_cfg_regs;
  localparam logic [15:0] PART_ID = 16'h6B1E; // arbitrary value
  localparam int unsigned ADDR_W = 8;
  int mismatches = 0;
  int comparisons = 0;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic CFG_REQ, CFG_WR, CFG_ACK;
  logic [ADDR_W-1:0] CFG_ADDR;
  logic [3:0] CFG_BE;
  logic [31:0] CFG_WDATA, CFG_RDATA, q, e;
  logic ak;
  logic [6:0] ev = '0;
  logic MST_DATA_PERR, TGT_ABORT_SIGNALED, MST_TGT_ABORT_RCVD, MST_MASTER_ABORT_RCVD;
  logic ADDR_PERR, TGT_DATA_PERR, SYS_ERR_REQ, oe_x, pe_x;
  logic PRI_IO_VALID = 1'b0;
  logic PRI_IO_WRITE = 1'b0;
  logic [15:0] PRI_IO_ADDR = 16'h0000;
  logic PRI_MEM_VALID = 1'b0;
  logic SEC_MEMIO_VALID = 1'b0;
  logic IO_CLAIM, MEM_CLAIM, PALETTE_CLAIM, SEC_CLAIM, PRI_MASTER_PERMIT, FB2B_PERMIT;
  logic PERR_ACTION, PRIMARY_SYSTEM_ERROR_OUT_N_O, PRIMARY_SYSTEM_ERROR_OUT_OE;
  logic [15:0] cmd;
  // event pulses, one bit per engine report
  assign {SYS_ERR_REQ, TGT_DATA_PERR, ADDR_PERR, MST_MASTER_ABORT_RCVD, MST_TGT_ABORT_RCVD,
    TGT_ABORT_SIGNALED, MST_DATA_PERR} = ev;
  always #2 CLK = ~CLK;
  bcsr_cfg_regs #(.PART_ID(PART_ID), .ADDR_W(ADDR_W)) i_bcsr_cfg_regs (
    .CLK(CLK), .RST(RST), .CFG_REQ(CFG_REQ), .CFG_WR(CFG_WR), .CFG_ADDR(CFG_ADDR),
    .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .CFG_ACK(CFG_ACK),
    .MST_DATA_PERR(MST_DATA_PERR), .TGT_ABORT_SIGNALED(TGT_ABORT_SIGNALED),
    .MST_TGT_ABORT_RCVD(MST_TGT_ABORT_RCVD), .MST_MASTER_ABORT_RCVD(MST_MASTER_ABORT_RCVD),
    .ADDR_PERR(ADDR_PERR), .TGT_DATA_PERR(TGT_DATA_PERR), .SYS_ERR_REQ(SYS_ERR_REQ),
    .PRI_IO_VALID(PRI_IO_VALID), .PRI_IO_WRITE(PRI_IO_WRITE), .PRI_IO_ADDR(PRI_IO_ADDR),
    .PRI_MEM_VALID(PRI_MEM_VALID), .SEC_MEMIO_VALID(SEC_MEMIO_VALID),
    .IO_CLAIM(IO_CLAIM), .MEM_CLAIM(MEM_CLAIM), .PALETTE_CLAIM(PALETTE_CLAIM),
    .SEC_CLAIM(SEC_CLAIM), .PRI_MASTER_PERMIT(PRI_MASTER_PERMIT), .FB2B_PERMIT(FB2B_PERMIT),
    .PERR_ACTION(PERR_ACTION), .PRIMARY_SYSTEM_ERROR_OUT_N_O(PRIMARY_SYSTEM_ERROR_OUT_N_O),
    .PRIMARY_SYSTEM_ERROR_OUT_OE(PRIMARY_SYSTEM_ERROR_OUT_OE)
  );
  bcsr_host_model #(.ADDR_W(ADDR_W)) i_bcsr_host_model (
    .CLK(CLK), .CFG_REQ(CFG_REQ), .CFG_WR(CFG_WR), .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE),
    .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .CFG_ACK(CFG_ACK)
  );
  // ==========================================================
  // access tasks
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    i_bcsr_host_model.xfer(1'b1, a, be, d, q, ak);
    `CHK("write ack", 1'b1, ak)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    i_bcsr_host_model.xfer(1'b0, a, 4'h0, 32'h0000_0000, q, ak);
    `CHK("read ack", 1'b1, ak)
    `CHK("read data", ex, q)
  endtask
  task automatic dec(input logic [15:0] a, input logic w, input logic pal);
    PRI_IO_VALID = 1'b1;
    PRI_IO_WRITE = w;
    PRI_IO_ADDR = a;
    PRI_MEM_VALID = 1'b1;
    SEC_MEMIO_VALID = 1'b1;
    @(posedge CLK);
    #1;
    PRI_IO_VALID = 1'b0;
    PRI_MEM_VALID = 1'b0;
    SEC_MEMIO_VALID = 1'b0;
    `CHK("io claim", cmd[0], IO_CLAIM)
    `CHK("mem claim", cmd[1], MEM_CLAIM)
    `CHK("sec claim", cmd[2], SEC_CLAIM)
    `CHK("palette claim", pal && w && cmd[5], PALETTE_CLAIM)
    @(posedge CLK);
    #1;
  endtask
  // status flags expected after one event
  function automatic logic [31:0] flag_exp(input int i, input logic p, input logic s);
    case (i)
      0: flag_exp = p ? 32'h8100_0000 : 32'h8000_0000;
      1: flag_exp = 32'h0800_0000;
      2: flag_exp = 32'h1000_0000;
      3: flag_exp = 32'h2000_0000;
      4: flag_exp = (p && s) ? 32'hC000_0000 : 32'h8000_0000;
      5: flag_exp = 32'h8000_0000;
      default: flag_exp = s ? 32'h4000_0000 : 32'h0000_0000;
    endcase
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #20000;
    mismatches++;
    print_verdict();
  end
  // ==========================================================
  // tests
  initial begin
    repeat (10) @(posedge CLK);
    #1;
    RST = 1'b0;
    rd(8'h04, 32'h02B0_0000);
    wr(8'h00, 4'hF, 32'hFFFF_FFFF);
    rd(8'h00, {PART_ID, 16'h0000});
    rd(8'h08, 32'h0000_0000);
    for (int c = 0; c < 2; c++) begin
      cmd = (c == 0) ? 16'h0367 : 16'h0000;
      wr(8'h04, 4'h3, {16'hFFFF, cmd | 16'hFC98});
      rd(8'h04, {16'h02B0, cmd});
      `CHK("master permit", cmd[2], PRI_MASTER_PERMIT)
      `CHK("fb2b permit", cmd[9], FB2B_PERMIT)
      dec(16'hFFC6, 1'b1, 1'b1);
      dec(16'h03C8, 1'b1, 1'b1);
      dec(16'h07C9, 1'b1, 1'b1);
      dec(16'h03C7, 1'b1, 1'b0);
      dec(16'h03C6, 1'b0, 1'b1);
      for (int i = 0; i < 7; i++) begin
        e = flag_exp(i, cmd[6], cmd[8]);
        oe_x = cmd[8] && (i == 6 || (i == 4 && cmd[6]));
        pe_x = cmd[6] && (i == 0 || i == 4 || i == 5);
        ev[i] = 1'b1;
        @(posedge CLK);
        #1;
        ev = '0;
        `CHK("serr drive", oe_x, PRIMARY_SYSTEM_ERROR_OUT_OE)
        `CHK("parity action", pe_x, PERR_ACTION)
        `CHK("serr level", 1'b0, PRIMARY_SYSTEM_ERROR_OUT_N_O)
        rd(8'h04, {16'h02B0, cmd} | e);
        wr(8'h04, 4'hF, {~e[31:16], cmd | 16'hFC98});
        rd(8'h04, {16'h02B0, cmd} | e);
        wr(8'h04, 4'h8, e);
        rd(8'h04, {16'h02B0, cmd});
      end
      if (c == 0) begin
        // mid-run reset returns command word and flags to zero
        ev[1] = 1'b1;
        @(posedge CLK);
        #1;
        ev = '0;
        RST = 1'b1;
        repeat (2) @(posedge CLK);
        #1;
        RST = 1'b0;
        rd(8'h04, 32'h02B0_0000);
        `CHK("reset permit", 1'b0, PRI_MASTER_PERMIT)
        `CHK("reset fb2b", 1'b0, FB2B_PERMIT)
      end
    end
    // a set in the clearing cycle wins; a clear outside byte 3 is ignored
    ev[1] = 1'b1;
    fork
      wr(8'h04, 4'h8, 32'h0800_0000);
      begin
        @(posedge CLK);
        #1;
        ev = '0;
      end
    join
    rd(8'h04, 32'h0AB0_0000);
    wr(8'h04, 4'h7, 32'hFF00_0000);
    rd(8'h04, 32'h0AB0_0000);
    wr(8'h04, 4'h8, 32'h0800_0000);
    rd(8'h04, 32'h02B0_0000);
    print_verdict();
  end
endmodule // tb_bcsr_cfg_regs
bind bcsr_cfg_regs bcsr_cfg_regs_assertions #(.PART_ID(PART_ID), .ADDR_W(ADDR_W))
  i_bcsr_cfg_regs_assertions (
    .CLK(CLK), .RST(RST), .CFG_REQ(CFG_REQ), .CFG_WR(CFG_WR), .CFG_ADDR(CFG_ADDR),
    .CFG_RDATA(CFG_RDATA), .CFG_ACK(CFG_ACK), .PRI_IO_VALID(PRI_IO_VALID),
    .PRI_IO_WRITE(PRI_IO_WRITE), .PRI_IO_ADDR(PRI_IO_ADDR), .PRI_MEM_VALID(PRI_MEM_VALID),
    .SEC_MEMIO_VALID(SEC_MEMIO_VALID), .IO_CLAIM(IO_CLAIM), .MEM_CLAIM(MEM_CLAIM),
    .PALETTE_CLAIM(PALETTE_CLAIM), .SEC_CLAIM(SEC_CLAIM), .PERR_ACTION(PERR_ACTION),
    .MST_DATA_PERR(MST_DATA_PERR), .TGT_DATA_PERR(TGT_DATA_PERR), .ADDR_PERR(ADDR_PERR),
    .SYS_ERR_REQ(SYS_ERR_REQ), .PRIMARY_SYSTEM_ERROR_OUT_OE(PRIMARY_SYSTEM_ERROR_OUT_OE)
  );
